// ---- mst_pkg.sv ----
package mst_pkg;

	// Register location and layout
	localparam logic [13:0] MST_REG_ADDR   = 14'h014d;
	localparam int          MST_DATA_W     = 16;
	localparam logic [15:0] MST_RESET_VAL  = 16'h0000;
	localparam int          MST_ENABLE_BIT = 12;
	localparam int          MST_NUM_MEM    = 4;

	// Per-memory start, done and pass positions, index 0 = backplane data
	localparam int MST_START_POS [MST_NUM_MEM] = '{11, 8, 5, 2};
	localparam int MST_DONE_POS  [MST_NUM_MEM] = '{10, 7, 4, 1};
	localparam int MST_PASS_POS  [MST_NUM_MEM] = '{9, 6, 3, 0};

	// Writable bits: reserved 15:13 plus enable and start bits
	localparam logic [15:0] MST_WR_MASK    = 16'hf924;

	// Default march pass length per memory
	localparam int MST_MEM_DEPTH  = 16;

	// Register port request carried as one group
	typedef struct packed {
		logic        cs;
		logic        wr;
		logic [13:0] addr;
		logic [15:0] wdata;
	} mst_req_t;

	// Per-engine state
	typedef enum logic [1:0] {
		MST_IDLE,
		MST_WRITE,
		MST_READ,
		MST_FINISH
	} mst_state_t;

endpackage

// ---- mst_engine.sv ----
module mst_engine #(
	parameter int DEPTH = mst_pkg::MST_MEM_DEPTH
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// Control
	input  wire logic start_i,
	input  wire logic enable_i,
	input  wire logic fault_i,
	// Result
	output logic      done_o,
	output logic      pass_o
);
	import mst_pkg::*;

	localparam int AW = $clog2(DEPTH);

	mst_state_t     state_ff, nxt_state;
	logic [AW-1:0]  addr_ff,  nxt_addr;
	logic           done_ff,  nxt_done;
	logic           pass_ff,  nxt_pass;
	logic [DEPTH-1:0] mem_ff, nxt_mem;

	// Write-all then read-back sweep over a flop array
	always_comb begin
		nxt_state = state_ff;
		nxt_addr  = addr_ff;
		nxt_done  = done_ff;
		nxt_pass  = pass_ff;
		nxt_mem   = mem_ff;
		case (state_ff)
			MST_IDLE: begin
				if (start_i && enable_i) begin
					nxt_state = MST_WRITE;
					nxt_addr  = '0;
					nxt_done  = 1'b0;
					nxt_pass  = 1'b1;
				end
			end
			MST_WRITE: begin
				nxt_mem[addr_ff] = ~addr_ff[0];
				if (addr_ff == AW'(DEPTH - 1)) begin
					nxt_state = MST_READ;
					nxt_addr  = '0;
				end else begin
					nxt_addr = addr_ff + 1'b1;
				end
			end
			MST_READ: begin
				if ((mem_ff[addr_ff] ^ fault_i) != ~addr_ff[0])
					nxt_pass = 1'b0;
				if (addr_ff == AW'(DEPTH - 1))
					nxt_state = MST_FINISH;
				else
					nxt_addr = addr_ff + 1'b1;
			end
			MST_FINISH: begin
				nxt_done  = 1'b1;
				nxt_state = MST_IDLE;
			end
			default: nxt_state = MST_IDLE;
		endcase
		if (!enable_i) begin
			nxt_state = MST_IDLE;
		end
	end

	// State registers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= MST_IDLE;
			addr_ff  <= '0;
			done_ff  <= 1'b0;
			pass_ff  <= 1'b0;
			mem_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			addr_ff  <= nxt_addr;
			done_ff  <= nxt_done;
			pass_ff  <= nxt_pass;
			mem_ff   <= nxt_mem;
		end
	end

	assign done_o = done_ff;
	assign pass_o = pass_ff & done_ff; // Pass only meaningful once done
endmodule

// ---- mst_ctrl.sv ----
module mst_ctrl #(
	parameter int DEPTH = mst_pkg::MST_MEM_DEPTH
) (
	// Clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           sys_rst_i,
	// Register port
	input  wire mst_pkg::mst_req_t              req_i,
	output logic [mst_pkg::MST_DATA_W-1:0]      rdata_o,
	// Memory fault injection, mode output and busy outputs
	input  wire logic [mst_pkg::MST_NUM_MEM-1:0] fault_i,
	output logic                                selftest_mode_o,
	output logic [mst_pkg::MST_NUM_MEM-1:0]     test_busy_o
);
	import mst_pkg::*;

	logic [15:0]            ctrl_ff, nxt_ctrl;
	logic [15:0]            rdata_ff, nxt_rdata;
	logic [MST_NUM_MEM-1:0] start_prev_ff, nxt_start_prev;
	logic [MST_NUM_MEM-1:0] busy_ff, nxt_busy;
	logic [MST_NUM_MEM-1:0] launch, done, pass, start_lvl;
	logic                   hit;

	// Longest run: write sweep, read sweep, finish and sampling slack
	localparam int FIN_MAX = 2 * DEPTH + 3;

	assign hit = req_i.cs && (req_i.addr == MST_REG_ADDR);

	// Writable bits update on a hit write; status bits never stored
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (hit && req_i.wr)
			nxt_ctrl = req_i.wdata & MST_WR_MASK;
	end

	genvar g;
	generate
		for (g = 0; g < MST_NUM_MEM; g++) begin : g_mem
			// Rising edge of a start bit launches that engine
			assign start_lvl[g] = ctrl_ff[MST_START_POS[g]];
			assign launch[g] = start_lvl[g] & ~start_prev_ff[g];
			mst_engine #(
				.DEPTH(DEPTH)
			) u_eng (
				.clk_i    (clk_i),
				.sys_rst_i(sys_rst_i),
				.start_i  (launch[g]),
				.enable_i (ctrl_ff[MST_ENABLE_BIT]),
				.fault_i  (fault_i[g]),
				.done_o   (done[g]),
				.pass_o   (pass[g])
			);
		end
	endgenerate

	// Read image assembles control and live status; busy tracks real runs
	always_comb begin
		nxt_start_prev = start_lvl;
		nxt_rdata      = ctrl_ff;
		nxt_busy       = busy_ff;
		for (int i = 0; i < MST_NUM_MEM; i++) begin
			nxt_rdata[MST_DONE_POS[i]] = done[i];
			nxt_rdata[MST_PASS_POS[i]] = pass[i];
			// A launch ignored outside test mode never shows as busy
			if (done[i] || !ctrl_ff[MST_ENABLE_BIT])
				nxt_busy[i] = 1'b0;
			if (launch[i] && ctrl_ff[MST_ENABLE_BIT])
				nxt_busy[i] = 1'b1;
		end
		if (!(hit && !req_i.wr))
			nxt_rdata = rdata_ff;
	end

	// Registers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_ff       <= MST_RESET_VAL;
			rdata_ff      <= MST_RESET_VAL;
			start_prev_ff <= '0;
			busy_ff       <= '0;
		end else begin
			ctrl_ff       <= nxt_ctrl;
			rdata_ff      <= nxt_rdata;
			start_prev_ff <= nxt_start_prev;
			busy_ff       <= nxt_busy;
		end
	end

	assign rdata_o         = rdata_ff;
	assign selftest_mode_o = ctrl_ff[MST_ENABLE_BIT];
	assign test_busy_o     = busy_ff & ~done;

	// Assertions
	property p_mode;
		@(posedge clk_i) disable iff (sys_rst_i)
		(hit && req_i.wr)
			|=> selftest_mode_o == $past(req_i.wdata[MST_ENABLE_BIT]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode mismatch");

	property p_launch;
		@(posedge clk_i) disable iff (sys_rst_i)
		(launch[0] && ctrl_ff[MST_ENABLE_BIT]) |=> !done[0];
	endproperty
	a_launch: assert property (p_launch) else $error("done not cleared");

	property p_finish;
		@(posedge clk_i) disable iff (sys_rst_i)
		(launch[1] && ctrl_ff[MST_ENABLE_BIT] && req_i == '0)
			|-> ##[1:FIN_MAX] done[1];
	endproperty
	a_finish: assert property (p_finish) else $error("test never done");

	property p_pass;
		@(posedge clk_i) disable iff (sys_rst_i)
		($rose(done[3]) && $past(fault_i[3], 2)) |-> !pass[3];
	endproperty
	a_pass: assert property (p_pass) else $error("fault not reported");

	property p_ro;
		@(posedge clk_i) disable iff (sys_rst_i)
		(hit && req_i.wr) |=> (ctrl_ff & ~MST_WR_MASK) == '0;
	endproperty
	a_ro: assert property (p_ro) else $error("status bit stored");

	property p_start3;
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(start_lvl[3]) |-> launch[3];
	endproperty
	a_start3: assert property (p_start3) else $error("no launch");

	property p_start2;
		@(posedge clk_i) disable iff (sys_rst_i)
		launch[2] |-> ctrl_ff[MST_START_POS[2]];
	endproperty
	a_start2: assert property (p_start2) else $error("bad launch");

	c_done0: cover property (@(posedge clk_i) done[0] && pass[0]);
	c_fail1: cover property (@(posedge clk_i) done[1] && !pass[1]);
	c_all:   cover property (@(posedge clk_i) &done);
endmodule

// ---- memory_self_test_control_tb_top.sv ----
module memory_self_test_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mst_pkg::*;

	logic        clk_i;
	logic        sys_rst_i;
	mst_req_t    req_i;
	logic [15:0] rdata_o;
	logic [3:0]  fault_i;
	logic        selftest_mode_o;
	logic [3:0]  test_busy_o;
	int          errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	logic [15:0] rd;
	logic [15:0] sb;
	logic [15:0] mk;
	logic [15:0] ex;

	// Short runs keep each memory test near ten cycles
	mst_ctrl #(.DEPTH(4)) u_dut (
		.clk_i           (clk_i),
		.sys_rst_i       (sys_rst_i),
		.req_i           (req_i),
		.rdata_o         (rdata_o),
		.fault_i         (fault_i),
		.selftest_mode_o (selftest_mode_o),
		.test_busy_o     (test_busy_o)
	);

	// Clock generator
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle register write, returns once the stored value has settled
	task automatic wr(input logic [13:0] a, input logic [15:0] d);
		@(posedge clk_i);
		req_i <= '{cs: 1'b1, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk_i);
		req_i <= '0;
		#1;
	endtask

	// One-cycle register read, data settles after the taking edge
	task automatic rdr(input logic [13:0] a);
		@(posedge clk_i);
		req_i <= '{cs: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(posedge clk_i);
		req_i <= '0;
		#1 rd = rdata_o;
	endtask

	task automatic report_and_stop();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end

	// Main sequence
	initial begin
		req_i = '0;
		fault_i = 4'h0;
		sys_rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rdr(MST_REG_ADDR);
		chk(rd, 16'h0000);
		chk({15'h0, selftest_mode_o}, 16'h0000);
		// Status bits ignore writes; other addresses are not decoded
		wr(MST_REG_ADDR, 16'h06db);
		rdr(MST_REG_ADDR);
		chk(rd, 16'h0000);
		wr(14'h014c, 16'h1000);
		rdr(MST_REG_ADDR);
		chk(rd, 16'h0000);
		// A start without test mode must not launch an engine
		wr(MST_REG_ADDR, 16'h0800);
		chk({12'h0, test_busy_o}, 16'h0000);
		wr(MST_REG_ADDR, 16'h1000);
		rdr(MST_REG_ADDR);
		chk(rd, 16'h1000);
		chk({15'h0, selftest_mode_o}, 16'h0001);
		// Each memory in turn, odd ones with an injected fault
		for (int i = 0; i < 4; i++) begin
			sb = 16'h1000 | (16'h0001 << MST_START_POS[i]);
			mk = (16'h0001 << MST_DONE_POS[i]) | (16'h0001 << MST_PASS_POS[i]);
			ex = 16'h0001 << MST_DONE_POS[i];
			if (i % 2 == 0) begin
				ex = ex | (16'h0001 << MST_PASS_POS[i]);
			end
			fault_i <= (i % 2 == 1) ? (4'h1 << i) : 4'h0;
			wr(MST_REG_ADDR, sb);
			rdr(MST_REG_ADDR);
			chk(rd & mk, 16'h0000);
			chk({15'h0, test_busy_o[i]}, 16'h0001);
			for (int k = 0; k < 40 && rd[MST_DONE_POS[i]] !== 1'b1; k++) begin
				rdr(MST_REG_ADDR);
			end
			chk(rd & mk, ex);
			chk({15'h0, test_busy_o[i]}, 16'h0000);
			wr(MST_REG_ADDR, 16'h1000);
		end
		fault_i <= 4'h0;
		wr(MST_REG_ADDR, 16'h0000);
		chk({15'h0, selftest_mode_o}, 16'h0000);
		// Results outlive test mode: all done, passes on memories 0 and 2
		rdr(MST_REG_ADDR);
		chk(rd, 16'h069a);
		// Reset after all runs have finished clears every bit again
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rdr(MST_REG_ADDR);
		chk(rd, 16'h0000);
		chk({12'h0, test_busy_o}, 16'h0000);
		report_and_stop();
	end
endmodule
